// *** logic/cfg_decode_if.sv ***
`timescale 1ns/1ps
interface cfg_decode_if;
  logic [31:0] config_word;
  logic [31:0] deadman_terminal;
  logic        deadman_reserved;
  logic [1:0]  window_size;
  logic [7:0]  window_open_eighths;

  modport decoder (
    input  config_word,
    output deadman_terminal,
    output deadman_reserved,
    output window_size,
    output window_open_eighths
  );
  modport user (
    output config_word,
    input  deadman_terminal,
    input  deadman_reserved,
    input  window_size,
    input  window_open_eighths
  );
endinterface

// *** logic/cfg_field_decode.sv ***
`timescale 1ns/1ps
module cfg_field_decode (
  cfg_decode_if.decoder dec
);

  logic [4:0] code;

  assign code = dec.config_word[cfg_word_pkg::DEADMAN_COUNT_MSB:cfg_word_pkg::DEADMAN_COUNT_LSB];

  always_comb begin
    dec.deadman_terminal = 32'h0000_0000;
    dec.deadman_reserved = (code > cfg_word_pkg::DEADMAN_CODE_MAX);
    // Reserved codes give a zero terminal count so the timer never fires on junk.
    if (!dec.deadman_reserved) begin
      dec.deadman_terminal = 32'h0000_0001 << (5'(code) + 5'(cfg_word_pkg::DEADMAN_SHIFT_BASE));
    end
  end

  assign dec.window_size =
    dec.config_word[cfg_word_pkg::WINDOW_SIZE_MSB:cfg_word_pkg::WINDOW_SIZE_LSB];

  always_comb begin
    case (dec.window_size)
      cfg_word_pkg::WIN_25:   dec.window_open_eighths = 8'h02;
      cfg_word_pkg::WIN_37_5: dec.window_open_eighths = 8'h03;
      cfg_word_pkg::WIN_50:   dec.window_open_eighths = 8'h04;
      cfg_word_pkg::WIN_75:   dec.window_open_eighths = 8'h06;
      default:                dec.window_open_eighths = 8'h06;
    endcase
  end

endmodule

// *** logic/cfg_word_pkg.sv ***
package cfg_word_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] CONFIG_WORD_OFFSET  = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET      = 8'h04;
  localparam logic [7:0] STATUS_OFFSET       = 8'h08;
  localparam logic [7:0] DEADMAN_TERM_OFFSET = 8'h0C;
  localparam logic [7:0] WATCHDOG_OPEN_OFFSET = 8'h10;

  // Field positions in the configuration word.
  localparam int DEADMAN_ENABLE_BIT   = 31;
  localparam int DEADMAN_COUNT_MSB    = 30;
  localparam int DEADMAN_COUNT_LSB    = 26;
  localparam int WINDOW_SIZE_MSB      = 25;
  localparam int WINDOW_SIZE_LSB      = 24;
  localparam int WATCHDOG_ENABLE_BIT  = 23;
  localparam int WINDOW_DISABLE_BIT   = 22;
  localparam int STOP_ON_PROGRAM_BIT  = 21;

  // Control register bit positions.
  localparam int CTRL_DEADMAN_ON_BIT  = 0;
  localparam int CTRL_WATCHDOG_ON_BIT = 1;

  // Deadman count select: terminal count is 2^(code + base).
  localparam int          DEADMAN_SHIFT_BASE = 8;
  localparam logic [4:0]  DEADMAN_CODE_MAX   = 5'h17;

  // Window size codes.
  localparam logic [1:0] WIN_25   = 2'h3;
  localparam logic [1:0] WIN_37_5 = 2'h2;
  localparam logic [1:0] WIN_50   = 2'h1;
  localparam logic [1:0] WIN_75   = 2'h0;

  // Reset values.
  localparam logic [31:0] CONFIG_RESET  = 32'h0000_0000;
  localparam logic [1:0]  CONTROL_RESET = 2'h0;

  // Load sequence length in cycles after reset release.
  localparam int LOAD_CYCLES = 1;

endpackage

// *** logic/watchdog_deadman_config_word.sv ***
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Deadman fuse 1 forces deadman on; fuse 0 starts off, software may enable.
// - Count select bits 30..26 give terminal count 2^(code+8); codes above 10111 reserved.
// - Window size bits 25..24: 11=25%, 10=37.5%, 01=50%, 00=75%.
// - Watchdog fuse 1 forces watchdog on; fuse 0 starts off, software may enable.
// - Window disable 1 means non-window mode; 0 means windowed service only.
// - Stop-on-program 1 halts watchdog during flash programming; 0 keeps counting.
module watchdog_deadman_config_word (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] nvm_config_word,
  input  wire logic        flash_programming,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             config_valid,
  output logic             deadman_enabled,
  output logic      [31:0] deadman_terminal,
  output logic             watchdog_enabled,
  output logic             watchdog_windowed,
  output logic      [7:0]  watchdog_open_eighths,
  output logic             watchdog_count_halt
);

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01
  } load_state_t;

  load_state_t state_reg;
  load_state_t state_next;
  logic [31:0] config_reg;
  logic [31:0] config_next;
  logic [1:0]  control_reg;
  logic [1:0]  control_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        err_reg;
  logic        err_next;

  logic        deadman_fuse;
  logic        watchdog_fuse;
  logic        access;
  logic        deadman_reserved;

  cfg_decode_if dec_if ();

  cfg_field_decode u_decode (
    .dec (dec_if.decoder)
  );

  assign dec_if.config_word = config_reg;
  assign deadman_reserved   = dec_if.deadman_reserved;

  assign deadman_fuse  = config_reg[cfg_word_pkg::DEADMAN_ENABLE_BIT];
  assign watchdog_fuse = config_reg[cfg_word_pkg::WATCHDOG_ENABLE_BIT];

  // one load at reset release, then frozen.
  always_comb begin
    state_next  = state_reg;
    config_next = config_reg;
    case (state_reg)
      ST_LOAD: begin
        config_next = nvm_config_word;
        state_next  = ST_RUN;
      end
      ST_RUN: begin
        config_next = config_reg;
      end
      default: begin
        state_next = ST_LOAD;
      end
    endcase
  end

  assign access = psel & penable;

  // Software enables; a blown fuse pins the bit high so writes cannot clear it.
  always_comb begin
    control_next = control_reg;
    if (access && pwrite && paddr == cfg_word_pkg::CONTROL_OFFSET) begin
      control_next = pwdata[1:0];
    end
    if (state_reg == ST_RUN && deadman_fuse) begin
      control_next[cfg_word_pkg::CTRL_DEADMAN_ON_BIT] = 1'b1;
    end
    if (state_reg == ST_RUN && watchdog_fuse) begin
      control_next[cfg_word_pkg::CTRL_WATCHDOG_ON_BIT] = 1'b1;
    end
  end

  // Register reads; the configuration word is read-only and writes to it are errors.
  always_comb begin
    prdata_next = 32'h0000_0000;
    err_next    = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        cfg_word_pkg::CONFIG_WORD_OFFSET: begin
          prdata_next = config_reg;
          err_next    = pwrite;
        end
        cfg_word_pkg::CONTROL_OFFSET: begin
          prdata_next = {30'h0, control_reg};
        end
        cfg_word_pkg::STATUS_OFFSET: begin
          prdata_next = {27'h0, deadman_reserved, watchdog_count_halt,
                         watchdog_windowed, watchdog_enabled, deadman_enabled};
          err_next    = pwrite;
        end
        cfg_word_pkg::DEADMAN_TERM_OFFSET: begin
          prdata_next = dec_if.deadman_terminal;
          err_next    = pwrite;
        end
        cfg_word_pkg::WATCHDOG_OPEN_OFFSET: begin
          prdata_next = {24'h00_0000, dec_if.window_open_eighths};
          err_next    = pwrite;
        end
        default: begin
          err_next = 1'b1;
        end
      endcase
    end else if (access) begin
      prdata_next = prdata_reg;
      err_next    = err_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_LOAD;
      config_reg  <= cfg_word_pkg::CONFIG_RESET;
      control_reg <= cfg_word_pkg::CONTROL_RESET;
      prdata_reg  <= 32'h0000_0000;
      err_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      config_reg  <= config_next;
      control_reg <= control_next;
      prdata_reg  <= prdata_next;
      err_reg     <= err_next;
    end
  end

  // Zero wait states: data is captured in setup and answered in the access cycle.
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = access & err_reg;

  assign config_valid     = (state_reg == ST_RUN);
  assign deadman_enabled  = control_reg[cfg_word_pkg::CTRL_DEADMAN_ON_BIT];
  assign watchdog_enabled = control_reg[cfg_word_pkg::CTRL_WATCHDOG_ON_BIT];
  assign deadman_terminal = dec_if.deadman_terminal;
  // windowed mode when disable bit is zero.
  assign watchdog_windowed = config_valid & ~config_reg[cfg_word_pkg::WINDOW_DISABLE_BIT];
  assign watchdog_open_eighths = dec_if.window_open_eighths;
  // halt only while programming with the stop bit set.
  assign watchdog_count_halt = config_reg[cfg_word_pkg::STOP_ON_PROGRAM_BIT] & flash_programming;

endmodule

// *** sim/watchdog_deadman_config_word_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected %0t got %h want %h", $time, (a), (b)); end end
module watchdog_deadman_config_word_tb;
  logic        pclk, presetn, flash_programming, psel, penable, pwrite, pready, pslverr;
  logic        config_valid, deadman_enabled, watchdog_enabled, watchdog_windowed;
  logic        watchdog_count_halt, rerr;
  logic [7:0]  paddr, watchdog_open_eighths;
  logic [31:0] nvm_config_word, pwdata, prdata, deadman_terminal, rdata, w;
  int          miscompares, total_checks, cycles;
  logic [31:0] words [4] = '{32'h83A0_005A, 32'h5E40_00A5, 32'h6140_0001, 32'h84E0_0080};
  logic [7:0]  eighths [4] = '{8'h06, 8'h04, 8'h03, 8'h02};
  // Terminal counts per word: codes 0 and 23, a reserved code, then code 1.
  logic [31:0] terms [4] = '{32'h0000_0100, 32'h8000_0000, 32'h0000_0000, 32'h0000_0200};

  watchdog_deadman_config_word dut (
    .pclk                  (pclk),
    .presetn               (presetn),
    .nvm_config_word       (nvm_config_word),
    .flash_programming     (flash_programming),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .config_valid          (config_valid),
    .deadman_enabled       (deadman_enabled),
    .deadman_terminal      (deadman_terminal),
    .watchdog_enabled      (watchdog_enabled),
    .watchdog_windowed     (watchdog_windowed),
    .watchdog_open_eighths (watchdog_open_eighths),
    .watchdog_count_halt   (watchdog_count_halt)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    {presetn, flash_programming, psel, penable, pwrite} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    nvm_config_word = 32'h0;
    for (int i = 0; i < 4; i++) begin
      w = words[i];
      @(posedge pclk);
      presetn <= 1'b0;
      nvm_config_word <= w;
      repeat (6) @(posedge pclk);
      `CHK({config_valid, pready}, 2'h1)
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      `CHK(config_valid, 1'b1)
      `CHK(deadman_enabled, w[31])
      `CHK(watchdog_enabled, w[23])
      `CHK(deadman_terminal, terms[i])
      `CHK(watchdog_open_eighths, eighths[w[25:24]])
      `CHK(watchdog_windowed, !w[22])
      `CHK(watchdog_count_halt, 1'b0)
      @(posedge pclk);
      flash_programming <= 1'b1;
      nvm_config_word <= ~w;
      #1;
      `CHK(watchdog_count_halt, w[21])
      @(posedge pclk);
      flash_programming <= 1'b0;
      apb(1'b1, 8'h00, 32'h0);
      `CHK(rerr, 1'b1)
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdata, w)
      `CHK(rerr, 1'b0)
      apb(1'b1, 8'h04, 32'h0);
      `CHK(rerr, 1'b0)
      @(posedge pclk);
      #1;
      `CHK({watchdog_enabled, deadman_enabled}, {w[23], w[31]})
      apb(1'b1, 8'h04, 32'h3);
      @(posedge pclk);
      #1;
      `CHK({watchdog_enabled, deadman_enabled}, 2'h3)
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rdata, {27'h0, w[30:29] == 2'h3, 1'b0, ~w[22], 2'h3})
      apb(1'b0, 8'h0C, 32'h0);
      `CHK(rdata, terms[i])
      apb(1'b0, 8'h10, 32'h0);
      `CHK(rdata, {24'h0, eighths[w[25:24]]})
      apb(1'b0, 8'h14, 32'h0);
      `CHK(rerr, 1'b1)
    end
    wrap_up();
  end
endmodule

// *** sim/wdc_props.sv ***
`timescale 1ns/1ps
module wdc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [31:0] nvm_config_word,
  input wire logic        flash_programming,
  input wire logic        config_valid,
  input wire logic        deadman_enabled,
  input wire logic [31:0] deadman_terminal,
  input wire logic        watchdog_enabled,
  input wire logic        watchdog_windowed,
  input wire logic [7:0]  watchdog_open_eighths,
  input wire logic        watchdog_count_halt
);
  logic [31:0] word_reg;
  logic [4:0]  code;
  logic [1:0]  ws;
  assign code = word_reg[30:26];
  assign ws = word_reg[25:24];
  // Mirrors the load, since the latched word itself is not visible at the ports.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      word_reg <= 32'h0000_0000;
    else if (!config_valid)
      word_reg <= nvm_config_word;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence loaded_s;
    config_valid ##1 config_valid;
  endsequence
  dm_forced_a: assert property (loaded_s ##0 word_reg[31] |-> ##[0:1] deadman_enabled)
    else $error("deadman fuse not forcing");
  wd_forced_a: assert property (loaded_s ##0 word_reg[23] |-> ##[0:1] watchdog_enabled)
    else $error("watchdog fuse not forcing");
  term_count_a: assert property (config_valid |-> deadman_terminal ==
    ((code > 5'h17) ? 32'h0 : (32'h1 << (code + 5'h08)))) else $error("bad terminal count");
  window_size_a: assert property (config_valid |-> watchdog_open_eighths ==
    ((ws == 2'h3) ? 8'h02 : (ws == 2'h2) ? 8'h03 : (ws == 2'h1) ? 8'h04 : 8'h06))
    else $error("bad window size");
  window_mode_a: assert property (config_valid |-> watchdog_windowed == !word_reg[22])
    else $error("bad window mode");
  program_halt_a: assert property (watchdog_count_halt ==
    (word_reg[21] && flash_programming)) else $error("bad program halt");
  word_held_a: assert property (config_valid |=>
    $stable(deadman_terminal) && $stable(watchdog_windowed)) else $error("word not held");
endmodule

bind watchdog_deadman_config_word wdc_props u_props (
  .pclk                  (pclk),
  .presetn               (presetn),
  .nvm_config_word       (nvm_config_word),
  .flash_programming     (flash_programming),
  .config_valid          (config_valid),
  .deadman_enabled       (deadman_enabled),
  .deadman_terminal      (deadman_terminal),
  .watchdog_enabled      (watchdog_enabled),
  .watchdog_windowed     (watchdog_windowed),
  .watchdog_open_eighths (watchdog_open_eighths),
  .watchdog_count_halt   (watchdog_count_halt)
);
